// >>> core/mq_defs.svh
/*
 * Holds the named constants of the multi-queue select and transfer core.
 * Assumes it is included by bare name from the package and the testbench.
 */
`ifndef MQ_DEFS_SVH
`define MQ_DEFS_SVH

`define MQ_DATA_W 36
`define MQ_NQ 8
`define MQ_QA_W 3
`define MQ_DEPTH 16
`define MQ_PTR_W 4
`define MQ_CNT_W 5
`define MQ_WADDR_W 6
`define MQ_RADDR_W 7
`define MQ_ID_HI_W 5
`define MQ_ID_LO_W 3
`define MQ_R_ID_HI 6
`define MQ_R_ID_LO 4
`define MQ_SOP_BIT 34
`define MQ_EOP_BIT 35

`endif

// >>> core/mq_pkg.sv
/*
 * Holds the types of the multi-queue core.
 * Assumes mq_defs.svh sits beside it on the include path.
 */
`include "mq_defs.svh"
package mq_pkg;
    typedef logic [`MQ_DATA_W-1:0] word_t;
    typedef logic [`MQ_QA_W-1:0] qaddr_t;
    typedef logic [`MQ_PTR_W-1:0] ptr_t;
    typedef logic [`MQ_CNT_W-1:0] cnt_t;

    typedef enum logic [1:0] {
        RD_RUN,
        RD_SWAP1,
        RD_SWAP2
    } rd_state_t;

    typedef struct packed {
        logic packet_mode;
        logic wsel_pend;
        qaddr_t wq_old;
        qaddr_t wq;
        logic full_n;
        rd_state_t rd_state;
        qaddr_t rq;
        logic out_valid_n;
        word_t dout;
        logic pkt_ready_n;
        logic wr_flag_sel;
        logic rd_flag_sel;
        logic [`MQ_NQ-1:0] pr_bus_n;
        logic [`MQ_NQ-1:0] af_bus;
    } core_state_t;
endpackage

// >>> core/multi_queue_core.sv
/*
 * Holds the queue selection, fall-through read path and packet-mode
 * write path of an eight-queue FIFO with common write and read ports.
 * Assumes one clock for both ports, synchronous inputs, and a writer
 * and reader that keep the packet-length and filler-word discipline.
 */
// Overview of operation
// RULE1: write address top bits match straps; enable picks queue, strobe flag bus.
// RULE2: read address seven bits; low three pick queue, top three device.
// RULE3: flag strobe with address enable low selects flag-bus driver by top bits.
// RULE4: read queue latched when read address enable high, read enable ignored.
// RULE5: reads stay on latest queue; change takes two read cycles.
// RULE6: a word may be delivered every edge, even during selection; the core delivers none on the edge ending RD_SWAP1.
// RULE7: selection cycle reads old queue only if read enable low; the core also reads it with read enable high while the valid flag is high.
// RULE8: empty/valid status shows the new queue one edge after selection.
// RULE9: old-queue last word then new-queue word fall through regardless.
// RULE10: reads from an empty selected queue are blocked.
// RULE11: no new word keeps output register, valid flag goes high.
// RULE12: output enable only tristates data; register still loads.
// RULE13: packet mode sampled at reset; almost-empty bus becomes packet ready.
// RULE14: writer makes packets at least four words long.
// RULE15: valid packet shown when packet ready and output valid both low.
// RULE16: writer finishes a packet before changing write queue.
// RULE17: writer adds one filler word on the cycle after queue change.
// RULE18: no start or end marker on the cycle after queue change.
// RULE19: packet selection cycle writes old queue if write enable low.
// RULE20: full flag shows new queue on the edge after selection request.
// RULE21: new queue writable from second edge after request if not full.
// RULE22: writes to a full selected queue are blocked.
// RULE23: bit 34 start marker, bit 35 end marker, stored with the word.
// RULE24: packet mode needs both data buses 36 bits wide.
// RULE25: reader discards the filler word falling through after a change.
`timescale 1ns/1ps
module multi_queue_core
    import mq_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic packet_mode_select,
    input wire logic [2:0] device_id_strap,
    input wire logic [`MQ_WADDR_W-1:0] write_queue_addr_bus,
    input wire logic write_addr_latch_en,
    input wire logic full_flag_bus_strobe,
    input wire logic write_en_n,
    input wire word_t din,
    input wire logic [`MQ_RADDR_W-1:0] read_queue_addr_bus,
    input wire logic read_addr_latch_en,
    input wire logic empty_flag_bus_strobe,
    input wire logic read_en_n,
    input wire logic output_en_n,
    output word_t dout,
    output logic dout_oe,
    output logic output_valid_n,
    output logic full_flag_n,
    output logic packet_ready_n,
    output logic [`MQ_NQ-1:0] prog_almost_empty_n,
    output logic prog_almost_empty_oe,
    output logic [`MQ_NQ-1:0] almost_full_flag_bus,
    output logic almost_full_flag_bus_oe,
    output logic read_start_marker,
    output logic read_end_marker
);

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    word_t mem_q [`MQ_NQ][`MQ_DEPTH];
    ptr_t wp_q [`MQ_NQ];
    ptr_t rp_q [`MQ_NQ];
    cnt_t cnt_q [`MQ_NQ];
    cnt_t pkts_q [`MQ_NQ];
    core_state_t s_q;
    core_state_t s_d;

    function automatic logic q_full(input cnt_t c);
        q_full = (c == cnt_t'(`MQ_DEPTH));
    endfunction

    function automatic logic id_match(input logic [2:0] a,
                                      input logic [2:0] id);
        id_match = (a == id);
    endfunction

    logic w_sel_me;
    logic w_flag_me;
    logic r_sel_me;
    logic r_flag_me;
    logic do_wr;
    logic do_rd;
    qaddr_t wr_target;
    word_t rd_word;
    logic rd_avail;

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    always_comb begin
        // RULE1: write select versus flag-bus select
        w_sel_me = write_addr_latch_en && !full_flag_bus_strobe &&
            id_match(write_queue_addr_bus[`MQ_WADDR_W-1:`MQ_QA_W],
                     device_id_strap);
        w_flag_me = !write_addr_latch_en && full_flag_bus_strobe &&
            id_match(write_queue_addr_bus[`MQ_WADDR_W-1:`MQ_QA_W],
                     device_id_strap);
        // RULE2: device bits 6..4, queue bits 2..0
        r_sel_me = read_addr_latch_en && !empty_flag_bus_strobe &&
            id_match(read_queue_addr_bus[`MQ_R_ID_HI:`MQ_R_ID_LO],
                     device_id_strap);
        // RULE3: low four bits ignored on flag select
        r_flag_me = !read_addr_latch_en && empty_flag_bus_strobe &&
            id_match(read_queue_addr_bus[`MQ_R_ID_HI:`MQ_R_ID_LO],
                     device_id_strap);
    end

    // ----------------------------------------------------------------
    // write path
    // ----------------------------------------------------------------
    always_comb begin
        // RULE19: selection cycle still targets the old queue
        wr_target = s_q.wq;
        // RULE21: one dead cycle after a request in packet mode
        // RULE22: full queue refuses writes
        do_wr = !write_en_n && !q_full(cnt_q[wr_target]) &&
            !(s_q.packet_mode && s_q.wsel_pend && s_q.wq_old != s_q.wq);
        // the dead cycle carries the filler into the old queue
        if (s_q.packet_mode && s_q.wsel_pend) begin
            wr_target = s_q.wq_old;
            do_wr = !write_en_n && !q_full(cnt_q[s_q.wq_old]);
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    always_comb begin
        rd_word = mem_q[s_q.rq][rp_q[s_q.rq]];
        // RULE10: nothing leaves an empty queue
        rd_avail = (cnt_q[s_q.rq] != cnt_t'(0));
        if (s_q.packet_mode && pkts_q[s_q.rq] == cnt_t'(0) &&
            s_q.out_valid_n)
            rd_avail = 1'b0;
        // RULE9: old word holds one edge, new word lands on the next
        // RULE7: selection cycle reads the old queue on read enable low, or while the valid flag is high
        case (s_q.rd_state)
            RD_SWAP1: do_rd = 1'b0;
            RD_SWAP2: do_rd = rd_avail;
            default: do_rd = rd_avail && (!read_en_n || s_q.out_valid_n);
        endcase
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.wsel_pend = 1'b0;
        if (w_sel_me) begin
            s_d.wq_old = s_q.wq;
            s_d.wq = write_queue_addr_bus[`MQ_QA_W-1:0];
            s_d.wsel_pend = 1'b1;
        end
        // RULE20: full flag follows the new queue on the next edge
        s_d.full_n = !q_full(cnt_q[s_d.wq]);

        case (s_q.rd_state)
            RD_RUN: s_d.rd_state = RD_RUN;
            RD_SWAP1: s_d.rd_state = RD_SWAP2;
            RD_SWAP2: s_d.rd_state = RD_RUN;
            default: s_d.rd_state = RD_RUN;
        endcase
        // RULE4: latch queue on enable, read enable ignored
        // RULE5: two cycles per change
        if (r_sel_me) begin
            s_d.rq = read_queue_addr_bus[`MQ_QA_W-1:0];
            s_d.rd_state = RD_SWAP1;
        end

        // RULE6: a word can land on every edge except the one ending RD_SWAP1
        // RULE12: register loads whatever the output enable
        if (do_rd) begin
            s_d.dout = rd_word;
            s_d.out_valid_n = 1'b0;
        end else if (!read_en_n || s_q.rd_state == RD_SWAP2) begin
            // RULE11: hold data, flag it stale
            s_d.out_valid_n = 1'b1;
        end
        // RULE8: status of new queue shown after selection
        if (s_q.rd_state == RD_SWAP1 && !rd_avail)
            s_d.out_valid_n = 1'b1;

        // RULE13: packet ready replaces almost-empty status
        s_d.pkt_ready_n = !(s_q.packet_mode &&
            pkts_q[s_d.rq] != cnt_t'(0));
        for (int i = 0; i < `MQ_NQ; i++) begin
            s_d.pr_bus_n[i] = s_q.packet_mode ?
                (pkts_q[i] == cnt_t'(0)) :
                (cnt_q[i] <= cnt_t'(`MQ_DEPTH/4));
            s_d.af_bus[i] = !(cnt_q[i] >= cnt_t'(`MQ_DEPTH-`MQ_DEPTH/4));
        end
        if (w_flag_me)
            s_d.wr_flag_sel = 1'b1;
        else if (!write_addr_latch_en && full_flag_bus_strobe)
            s_d.wr_flag_sel = 1'b0;
        if (r_flag_me)
            s_d.rd_flag_sel = 1'b1;
        else if (!read_addr_latch_en && empty_flag_bus_strobe)
            s_d.rd_flag_sel = 1'b0;
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= '0;
            s_q.full_n <= 1'b1;
            s_q.out_valid_n <= 1'b1;
            s_q.pkt_ready_n <= 1'b1;
            s_q.pr_bus_n <= '1;
            s_q.af_bus <= '1;
            s_q.rd_state <= RD_RUN;
            // RULE13: strap caught on every reset edge
            s_q.packet_mode <= packet_mode_select;
            for (int i = 0; i < `MQ_NQ; i++) begin
                wp_q[i] <= '0;
                rp_q[i] <= '0;
                cnt_q[i] <= '0;
                pkts_q[i] <= '0;
            end
        end else if (clk_en) begin
            s_q <= s_d;
            // mode only changes under reset
            s_q.packet_mode <= s_q.packet_mode;
            for (int i = 0; i < `MQ_NQ; i++) begin
                logic wi;
                logic ri;
                logic pe;
                logic pd;
                wi = do_wr && wr_target == qaddr_t'(i);
                ri = do_rd && s_q.rq == qaddr_t'(i);
                // RULE23: end marker counts a completed packet
                pe = wi && din[`MQ_EOP_BIT];
                pd = ri && rd_word[`MQ_EOP_BIT];
                if (wi)
                    wp_q[i] <= wp_q[i] + ptr_t'(1);
                if (ri)
                    rp_q[i] <= rp_q[i] + ptr_t'(1);
                if (wi && !ri)
                    cnt_q[i] <= cnt_q[i] + cnt_t'(1);
                else if (ri && !wi)
                    cnt_q[i] <= cnt_q[i] - cnt_t'(1);
                if (pe && !pd)
                    pkts_q[i] <= pkts_q[i] + cnt_t'(1);
                else if (pd && !pe)
                    pkts_q[i] <= pkts_q[i] - cnt_t'(1);
            end
            if (do_wr)
                mem_q[wr_target][wp_q[wr_target]] <= din;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign dout = s_q.dout;
    // RULE12: enable only gates the driver
    assign dout_oe = !output_en_n;
    assign output_valid_n = s_q.out_valid_n;
    assign full_flag_n = s_q.full_n;
    // RULE15: valid packet when both flags low
    assign packet_ready_n = s_q.pkt_ready_n;
    assign prog_almost_empty_n = s_q.pr_bus_n;
    assign prog_almost_empty_oe = s_q.rd_flag_sel;
    assign almost_full_flag_bus = s_q.af_bus;
    assign almost_full_flag_bus_oe = s_q.wr_flag_sel;
    assign read_start_marker = s_q.dout[`MQ_SOP_BIT];
    assign read_end_marker = s_q.dout[`MQ_EOP_BIT];

endmodule // multi_queue_core

// >>> test/mq_core_chk.sv
/*
 * Port-level checker for the eight-queue core.
 * Assumes one clock, synchronous active-high reset, bound to every core.
 */
`timescale 1ns/1ps
module mq_core_chk
    import mq_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [2:0] device_id_strap,
    input wire logic [5:0] write_queue_addr_bus,
    input wire logic write_addr_latch_en,
    input wire logic full_flag_bus_strobe,
    input wire logic [6:0] read_queue_addr_bus,
    input wire logic read_addr_latch_en,
    input wire logic empty_flag_bus_strobe,
    input wire logic output_en_n,
    input wire word_t dout,
    input wire logic dout_oe,
    input wire logic output_valid_n,
    input wire logic full_flag_n,
    input wire logic packet_ready_n,
    input wire logic prog_almost_empty_oe,
    input wire logic almost_full_flag_bus_oe,
    input wire logic read_start_marker,
    input wire logic read_end_marker
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_rstb;
        clk_en && empty_flag_bus_strobe && !read_addr_latch_en;
    endsequence
    sequence s_wstb;
        clk_en && full_flag_bus_strobe && !write_addr_latch_en;
    endsequence
    property p_oe; dout_oe == !output_en_n; endproperty
    property p_mark;
        {read_end_marker, read_start_marker} == dout[35:34];
    endproperty
    property p_rsel;
        s_rstb ##0 (read_queue_addr_bus[6:4] == device_id_strap)
            |=> prog_almost_empty_oe;
    endproperty
    property p_rclr;
        s_rstb ##0 (read_queue_addr_bus[6:4] != device_id_strap)
            |=> !prog_almost_empty_oe;
    endproperty
    property p_wsel;
        s_wstb ##0 (write_queue_addr_bus[5:3] == device_id_strap)
            |=> almost_full_flag_bus_oe;
    endproperty
    property p_wclr;
        s_wstb ##0 (write_queue_addr_bus[5:3] != device_id_strap)
            |=> !almost_full_flag_bus_oe;
    endproperty
    property p_rhold;
        !(clk_en && empty_flag_bus_strobe) |=> $stable(prog_almost_empty_oe);
    endproperty
    property p_rst;
        $fell(reset) |-> full_flag_n && output_valid_n && packet_ready_n;
    endproperty
    a_oe: assert property (p_oe)
        else $error("data enable not tied to output enable");
    a_mark: assert property (p_mark)
        else $error("markers differ from data bits");
    a_rsel: assert property (p_rsel)
        else $error("read flag bus not taken");
    a_rclr: assert property (p_rclr)
        else $error("read flag bus not released");
    a_wsel: assert property (p_wsel)
        else $error("write flag bus not taken");
    a_wclr: assert property (p_wclr)
        else $error("write flag bus not released");
    a_rhold: assert property (p_rhold)
        else $error("read flag bus enable moved without strobe");
    a_rst: assert property (p_rst)
        else $error("flags not idle after reset");
endmodule // mq_core_chk

bind multi_queue_core mq_core_chk u_chk (
    .clk(clk),
    .reset(reset),
    .clk_en(clk_en),
    .device_id_strap(device_id_strap),
    .write_queue_addr_bus(write_queue_addr_bus),
    .write_addr_latch_en(write_addr_latch_en),
    .full_flag_bus_strobe(full_flag_bus_strobe),
    .read_queue_addr_bus(read_queue_addr_bus),
    .read_addr_latch_en(read_addr_latch_en),
    .empty_flag_bus_strobe(empty_flag_bus_strobe),
    .output_en_n(output_en_n),
    .dout(dout),
    .dout_oe(dout_oe),
    .output_valid_n(output_valid_n),
    .full_flag_n(full_flag_n),
    .packet_ready_n(packet_ready_n),
    .prog_almost_empty_oe(prog_almost_empty_oe),
    .almost_full_flag_bus_oe(almost_full_flag_bus_oe),
    .read_start_marker(read_start_marker),
    .read_end_marker(read_end_marker)
);

// >>> test/mq_writer.sv
/*
 * Upstream writer model: selects a write queue, then sends a burst.
 * Assumes requests only while busy is low.
 */
`timescale 1ns/1ps
module mq_writer
    import mq_pkg::*;
(
    input wire logic clk,
    input wire logic go,
    input wire logic [5:0] req_addr,
    input wire logic [4:0] req_len,
    input wire word_t wdata,
    input wire logic framing,
    output logic [5:0] write_queue_addr_bus,
    output logic write_addr_latch_en,
    output logic write_en_n,
    output word_t din,
    output logic busy
);
    logic gap = 1'b0;
    logic [4:0] left = 5'h00;
    logic send;
    word_t framed;
    initial begin
        write_queue_addr_bus = 6'h00;
        write_addr_latch_en = 1'b0;
        write_en_n = 1'b1;
        din = '0;
        busy = 1'b0;
    end
    assign send = !(go && !busy) && !gap && left != 5'h00;
    // start marker on first word, end marker on last
    assign framed = framing ?
        {left == 5'h01, left == req_len, wdata[33:0]} : wdata;
    // full-width words; idle data toggles so nothing stale looks valid
    always @(posedge clk) begin
        write_addr_latch_en <= 1'b0;
        // filler on the cycle after a select
        write_en_n <= !(send || gap);
        din <= send ? framed : gap ? {2'b00, wdata[33:0]} : ~din;
        if (go && !busy) begin
            write_queue_addr_bus <= req_addr;
            write_addr_latch_en <= 1'b1;
            left <= req_len;
            gap <= 1'b1;
            busy <= 1'b1;
        end else if (gap) begin
            // burst ends before the next select
            gap <= 1'b0;
        end else if (left != 5'h00) begin
            left <= left - 5'h01;
        end else begin
            busy <= 1'b0;
        end
    end
endmodule // mq_writer

// >>> test/tb_multi_queue_select_and_packet_write.sv
/*
 * Self-checking bench for the eight-queue core, standard then packet mode.
 * Assumes the writer model and the bound checker are compiled with it.
 */
`timescale 1ns/1ps
`include "mq_defs.svh"
module tb_multi_queue_select_and_packet_write
    import mq_pkg::*;
;
    localparam logic [2:0] ID = 3'h5;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic clk_en = 1'b1;
    logic packet_mode_select = 1'b0;
    logic [2:0] device_id_strap = ID;
    logic [5:0] write_queue_addr_bus;
    logic [5:0] req_addr = 6'h00;
    logic write_addr_latch_en, write_en_n, busy;
    logic full_flag_bus_strobe = 1'b0;
    word_t din, dout;
    word_t wdata = '0;
    logic [6:0] read_queue_addr_bus = 7'h00;
    logic read_addr_latch_en = 1'b0;
    logic empty_flag_bus_strobe = 1'b0;
    logic read_en_n = 1'b1;
    logic output_en_n = 1'b0;
    logic go = 1'b0;
    logic [4:0] req_len = 5'h00;
    logic dout_oe, output_valid_n, full_flag_n, packet_ready_n;
    logic [7:0] prog_almost_empty_n, almost_full_flag_bus;
    logic prog_almost_empty_oe, almost_full_flag_bus_oe;
    logic read_start_marker, read_end_marker;
    word_t sb[8][$];
    word_t last = '0;
    qaddr_t wq = '0;
    qaddr_t rq_cur = '0;
    logic framing = 1'b0;
    int seed = 4510;
    int bad_count = 0;
    int num_checks = 0;
    int cyc = 0;

    multi_queue_core u_dut (
        .clk(clk),
        .reset(reset),
        .clk_en(clk_en),
        .packet_mode_select(packet_mode_select),
        .device_id_strap(device_id_strap),
        .write_queue_addr_bus(write_queue_addr_bus),
        .write_addr_latch_en(write_addr_latch_en),
        .full_flag_bus_strobe(full_flag_bus_strobe),
        .write_en_n(write_en_n),
        .din(din),
        .read_queue_addr_bus(read_queue_addr_bus),
        .read_addr_latch_en(read_addr_latch_en),
        .empty_flag_bus_strobe(empty_flag_bus_strobe),
        .read_en_n(read_en_n),
        .output_en_n(output_en_n),
        .dout(dout),
        .dout_oe(dout_oe),
        .output_valid_n(output_valid_n),
        .full_flag_n(full_flag_n),
        .packet_ready_n(packet_ready_n),
        .prog_almost_empty_n(prog_almost_empty_n),
        .prog_almost_empty_oe(prog_almost_empty_oe),
        .almost_full_flag_bus(almost_full_flag_bus),
        .almost_full_flag_bus_oe(almost_full_flag_bus_oe),
        .read_start_marker(read_start_marker),
        .read_end_marker(read_end_marker)
    );
    mq_writer u_wr (
        .clk(clk),
        .go(go),
        .req_addr(req_addr),
        .req_len(req_len),
        .wdata(wdata),
        .framing(framing),
        .write_queue_addr_bus(write_queue_addr_bus),
        .write_addr_latch_en(write_addr_latch_en),
        .write_en_n(write_en_n),
        .din(din),
        .busy(busy)
    );

    initial forever #25 clk = ~clk;
    always @(posedge clk) begin
        wdata <= word_t'({$random(seed), $random(seed)});
        output_en_n <= 1'($random(seed));
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            bad_count = bad_count + 1;
            summarize;
        end
    end
    // expected contents: depth-limited, select honoured only for our id
    always @(negedge clk) begin
        if (write_addr_latch_en && write_queue_addr_bus[5:3] == ID)
            wq = write_queue_addr_bus[2:0];
        if (!write_en_n && sb[wq].size() < `MQ_DEPTH)
            sb[wq].push_back(din);
    end

    task check(input word_t seen, input word_t exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task summarize;
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task wr(input logic [5:0] a, input logic [4:0] k);
        req_addr <= a;
        req_len <= k;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (40) begin
            @(posedge clk);
            if (!busy) break;
        end
    endtask
    task stb(input logic [2:0] id);
        read_queue_addr_bus <= {id, 4'hf};
        empty_flag_bus_strobe <= 1'b1;
        full_flag_bus_strobe <= 1'b1;
        @(posedge clk);
        empty_flag_bus_strobe <= 1'b0;
        full_flag_bus_strobe <= 1'b0;
        @(posedge clk);
    endtask
    // select with reads held off, then drain and compare in order
    task rd(input qaddr_t q);
        // a shown word is overwritten by the swap
        @(negedge clk);
        if (!output_valid_n)
            check(dout, sb[rq_cur].pop_front());
        @(posedge clk);
        rq_cur = q;
        read_queue_addr_bus <= {ID, 1'b0, q};
        read_addr_latch_en <= 1'b1;
        @(posedge clk);
        read_addr_latch_en <= 1'b0;
        repeat (3) @(posedge clk);
        read_en_n <= 1'b0;
        repeat (60) begin
            @(negedge clk);
            if (sb[q].size() == 0) break;
            if (!output_valid_n) begin
                last = sb[q].pop_front();
                check(dout, last);
            end
        end
        @(posedge clk);
        read_en_n <= 1'b1;
        repeat (2) @(negedge clk);
        check(word_t'(sb[q].size()), '0);
        check(output_valid_n, 1'b1);
        check(dout, last);
        @(posedge clk);
    endtask

    initial begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        @(negedge clk);
        check(full_flag_n, 1'b1);
        check(prog_almost_empty_n, 8'hff);
        check(almost_full_flag_bus, 8'hff);
        check(packet_ready_n, 1'b1);
        @(posedge clk);
        for (int q = 0; q < 8; q++)
            wr({ID, qaddr_t'(q)}, 5'(4 + ($random(seed) & 3)));
        // foreign id: selection ignored, words stay on queue 7
        wr({~ID, 3'h2}, 5'd3);
        stb(ID);
        stb(~ID);
        stb(ID);
        for (int q = 0; q < 8; q++)
            rd(qaddr_t'(q));
        wr({ID, 3'h3}, 5'd17);
        @(negedge clk);
        check(full_flag_n, 1'b0);
        check(almost_full_flag_bus[3], 1'b0);
        @(posedge clk);
        rd(3'h3);
        check(full_flag_n, 1'b1);
        rd(3'h5);
        // second reset with the packet strap high
        reset <= 1'b1;
        packet_mode_select <= 1'b1;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        packet_mode_select <= 1'b0;
        wq = '0;
        rq_cur = '0;
        framing <= 1'b1;
        @(posedge clk);
        wr({ID, 3'h1}, 5'd4);
        @(negedge clk);
        check(prog_almost_empty_n, 8'hfd);
        check(output_valid_n, 1'b1);
        check(packet_ready_n, 1'b1);
        @(posedge clk);
        wr({ID, 3'h0}, 5'd4);
        @(negedge clk);
        check({output_valid_n, packet_ready_n}, 2'b00);
        check(dout[35:34], 2'b00);
        @(posedge clk);
        read_en_n <= 1'b0;
        @(posedge clk);
        read_en_n <= 1'b1;
        @(negedge clk);
        check(read_start_marker, 1'b1);
        summarize;
    end
endmodule // tb_multi_queue_select_and_packet_write
